// ### hdl/bbss_pkg.sv
// How it works
// (R1) Enable pin high runs the converter; low means power-down.
// (R2) Enable must stay low at least 50 us before disable counts.
// (R3) Pin disable never turns on the active discharge path.
// (R4) Enable high, discharge bit set, soft-enable clear: stop and discharge.
// (R5) Above lockout with enable high: initialise, then read programmable memory.
// (R6) Soft-start ramps output at programmed rate only after memory read.
// (R7) Peak current limit acts per overcurrent action field.
// (R8) Hiccup: each overcurrent stops converter 100 ms, then retries.
// (R9) Shutdown action latches off until supply, enable or soft-enable cycle.
// (R10) Current-limit action keeps switching at peak limit, output may sag.
// (R11) Over-temperature stops switching until temperature falls by hysteresis.
// (R12) After thermal recovery run full soft-start, regulate to voltage setting.
// (R13) Buck PWM: D on, C off, A and B synchronous pair.
// (R14) Buck PWM cycle: A to upper, dead-time, B to lower, dead-time.
// (R15) Boost PWM: A on, B off, C to upper, dead-time, D to lower.
// (R16) PWM when forced mode is 0x2, otherwise only at high load.
// (R17) Buck PFM pulse: A, dead-time, B, then idle to lower threshold.
// (R18) Boost PFM pulse: A, C, dead-time, D, then all off; B off.
// (R19) PFM pulses repeat to upper threshold, then pause until lower.
// (R20) PFM only in automatic mode at light load, with hysteresis band.
// (R21) Near input voltage, alternate buck and boost patterns as needed.
// (R22) Forced mode defaults to normal automatic operation after power-up.
// (R23) Forced bypass turns A and D on, all else powered down.
// (R24) All comparator inputs synchronised to the clock before use.
// (R25) Never both switches of a leg on; handover passes a dead-time. Entering bypass hands B to A or C to D in one cycle, no dead-time.
package bbss_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned EN_LOW_US        = 50;
  localparam int unsigned EN_LOW_CYCLES    = EN_LOW_US * CLK_MHZ;
  localparam int unsigned HICCUP_MS        = 100;
  localparam int unsigned HICCUP_CYCLES    = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEAD_CYCLES      = 4;
  localparam int unsigned INIT_CYCLES      = 16;
  localparam int unsigned APB_AW           = 12;
  localparam logic [11:0] CFG_OFFSET       = 12'h000;
  localparam logic [11:0] VSET_OFFSET      = 12'h004;
  localparam logic [11:0] STATUS_OFFSET    = 12'h008;
  localparam logic [11:0] OTP_OFFSET       = 12'h00C;
  // Configuration register fields
  localparam int unsigned CFG_SOFT_EN_BIT  = 0;
  localparam int unsigned CFG_SOFT_DISCHARGE_EN_BIT    = 1;
  localparam int unsigned CFG_OCSEL_LSB    = 2;
  localparam int unsigned CFG_FORCED_MODE_SEL_LSB    = 4;
  localparam logic [31:0] CFG_RESET        = 32'h0000_0001;
  localparam logic [1:0]  OC_HICCUP        = 2'h0;
  localparam logic [1:0]  OC_SHUTDOWN      = 2'h1;
  localparam logic [1:0]  OC_LIMIT         = 2'h2;
  localparam logic [1:0]  FM_NORMAL        = 2'h0;
  localparam logic [1:0]  FM_BYPASS        = 2'h1;
  localparam logic [1:0]  FM_PWM           = 2'h2;
  localparam logic [7:0]  VSET_RESET       = 8'h00;
  localparam logic [15:0] RAMP_RESET       = 16'h0010;

  typedef struct packed {
    logic ipk_hi;
    logic ilim;
    logic ipk_lo;
    logic vout_hi;
    logic vout_lo;
    logic heavy_load;
    logic light_load;
    logic vin_gt_vout;
    logic over_temp;
    logic temp_recovered;
    logic uvlo_ok;
  } bbss_cmp_type;

  typedef struct packed {
    logic sw_a;
    logic sw_b;
    logic sw_c;
    logic sw_d;
  } bbss_sw_type;

  typedef enum logic [7:0] {
    ST_OFF      = 8'h01,
    ST_INIT     = 8'h02,
    ST_OTP      = 8'h04,
    ST_SOFT     = 8'h08,
    ST_RUN      = 8'h10,
    ST_HICCUP   = 8'h20,
    ST_LATCHED  = 8'h40,
    ST_THERMAL  = 8'h80
  } bbss_seq_type;

  typedef enum logic [5:0] {
    PH_IDLE  = 6'h01,
    PH_ON1   = 6'h02,
    PH_DT1   = 6'h04,
    PH_ON2   = 6'h08,
    PH_DT2   = 6'h10,
    PH_AHEAD = 6'h20
  } bbss_phase_type;
endpackage

// ### hdl/bbss_top.sv
`timescale 1ns/10ps
module bbss_top
  import bbss_pkg::*;
#(
  parameter int unsigned EN_LOW_CNT = EN_LOW_CYCLES,
  parameter int unsigned HICCUP_CNT = HICCUP_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [APB_AW-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               en_pin,
  input  wire bbss_cmp_type       cmp_in,
  input  wire logic [7:0]         otp_vset,
  input  wire logic [15:0]        otp_ramp,
  output bbss_sw_type             sw,
  output logic                    discharge_on,
  output logic                    bias_on,
  output logic [7:0]              vref_code,
  output logic                    regulating
);
  bbss_cmp_type   cmp_meta;
  bbss_cmp_type   cmp;
  logic           en_meta;
  logic           en_sync;
  logic [31:0]    converter_config_reg;
  logic [7:0]     vset;
  logic [7:0]     otp_vset_q;
  logic [15:0]    ramp_q;
  logic           oc_flag;
  logic           ot_flag;
  bbss_seq_type   seq;
  bbss_phase_type ph;
  logic [31:0]    en_low_cnt;
  logic           en_ok;
  logic [31:0]    timer;
  logic [15:0]    ramp_cnt;
  logic [2:0]     dt_cnt;
  logic           pfm_mode;
  logic           boost;
  logic           cycle_boost;
  logic           soft_en_prev;
  logic           cold_start;
  logic           run_req;
  logic           soft_en;
  logic           soft_discharge_en_bit;
  logic [1:0]     overcurrent_action_sel;
  logic [1:0]     forced_mode_sel;
  logic           bypass;
  logic           apb_wr;
  logic           apb_rd;
  logic           dt_done;
  logic           oc_trip;
  bbss_sw_type    next_sw;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign soft_en                = converter_config_reg[CFG_SOFT_EN_BIT];
  assign soft_discharge_en_bit              = converter_config_reg[CFG_SOFT_DISCHARGE_EN_BIT];
  assign overcurrent_action_sel = converter_config_reg[CFG_OCSEL_LSB +: 2];
  assign forced_mode_sel        = converter_config_reg[CFG_FORCED_MODE_SEL_LSB +: 2];
  assign bypass                 = (forced_mode_sel == FM_BYPASS) && en_ok && cmp.uvlo_ok;
  assign run_req                = en_ok && cmp.uvlo_ok && soft_en && !bypass; // R1
  assign apb_wr                 = psel && penable && pwrite;
  assign apb_rd                 = psel && !pwrite;
  assign pready                 = 1'b1;
  assign dt_done                = (dt_cnt == 3'(DEAD_CYCLES - 1));
  assign oc_trip                = cmp.ilim && (seq == ST_RUN || seq == ST_SOFT); // R7 R10

  // Two-stage synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= '0;
      cmp      <= '0;
      en_meta  <= 1'b0;
      en_sync  <= 1'b0;
    end else begin
      cmp_meta <= cmp_in; // R24
      cmp      <= cmp_meta; // R24
      en_meta  <= en_pin;
      en_sync  <= en_meta;
    end
  end

  // Enable low filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_low_cnt <= '0;
      en_ok      <= 1'b0;
    end else if (en_sync) begin
      en_low_cnt <= '0;
      en_ok      <= 1'b1; // R1
    end else if (en_low_cnt >= EN_LOW_CNT - 1) begin
      en_ok      <= 1'b0; // R2
    end else begin
      en_low_cnt <= en_low_cnt + 32'd1;
    end
  end

  // APB register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_config_reg <= CFG_RESET; // R22
      vset                 <= VSET_RESET;
      soft_en_prev         <= 1'b1;
    end else begin
      soft_en_prev <= soft_en;
      if (apb_wr && paddr == CFG_OFFSET) begin
        converter_config_reg <= merge_bytes(converter_config_reg, pwdata, pstrb) & 32'h0000_003F;
      end
      if (seq == ST_OTP && cold_start) begin
        vset <= otp_vset; // R5 R12
      end else if (apb_wr && paddr == VSET_OFFSET && pstrb[0]) begin
        vset <= pwdata[7:0];
      end
    end
  end

  // Sticky fault flags, cleared on read, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_flag <= 1'b0;
      ot_flag <= 1'b0;
    end else begin
      oc_flag <= oc_trip || (oc_flag && !(apb_rd && penable && paddr == STATUS_OFFSET));
      ot_flag <= cmp.over_temp || (ot_flag && !(apb_rd && penable && paddr == STATUS_OFFSET));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata  <= '0;
      case (paddr)
        CFG_OFFSET:    prdata <= converter_config_reg;
        VSET_OFFSET:   prdata <= {24'h000000, vset};
        STATUS_OFFSET: prdata <= {16'h0000, seq, 4'h0, boost, pfm_mode, ot_flag, oc_flag};
        OTP_OFFSET:    prdata <= {8'h00, otp_vset_q, ramp_q};
        default:       pslverr <= 1'b1;
      endcase
    end
  end

  // Start-up and protection sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq        <= ST_OFF;
      timer      <= '0;
      ramp_cnt   <= '0;
      vref_code  <= '0;
      otp_vset_q <= VSET_RESET;
      ramp_q     <= RAMP_RESET;
      cold_start <= 1'b1;
    end else if (!run_req && seq != ST_LATCHED) begin
      seq        <= ST_OFF; // R1
      vref_code  <= '0;
      timer      <= '0;
      cold_start <= 1'b1;
    end else if (cmp.over_temp && seq != ST_OFF && seq != ST_LATCHED) begin
      seq       <= ST_THERMAL; // R11
      vref_code <= '0;
    end else begin
      case (seq)
        ST_OFF: begin
          seq   <= ST_INIT; // R5
          timer <= '0;
        end
        ST_INIT: begin
          timer <= timer + 32'd1;
          if (timer == 32'(INIT_CYCLES - 1)) begin
            seq <= ST_OTP; // R5
          end
        end
        ST_OTP: begin
          otp_vset_q <= otp_vset; // R5
          ramp_q     <= (otp_ramp == 16'h0000) ? 16'h0001 : otp_ramp;
          ramp_cnt   <= '0;
          vref_code  <= '0;
          seq        <= ST_SOFT; // R6
          cold_start <= 1'b0;
        end
        ST_SOFT: begin
          if (oc_trip && overcurrent_action_sel == OC_HICCUP) begin
            seq   <= ST_HICCUP; // R8
            timer <= '0;
          end else if (oc_trip && overcurrent_action_sel == OC_SHUTDOWN) begin
            seq <= ST_LATCHED; // R9
          end else if (vref_code >= vset) begin
            vref_code <= vset;
            seq       <= ST_RUN; // R12
          end else if (ramp_cnt >= ramp_q - 16'h0001) begin
            ramp_cnt  <= '0;
            vref_code <= vref_code + 8'h01; // R6
          end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          vref_code <= vset;
          if (oc_trip && overcurrent_action_sel == OC_HICCUP) begin
            seq   <= ST_HICCUP; // R8
            timer <= '0;
          end else if (oc_trip && overcurrent_action_sel == OC_SHUTDOWN) begin
            seq <= ST_LATCHED; // R9
          end
        end
        ST_HICCUP: begin
          vref_code <= '0;
          timer     <= timer + 32'd1;
          if (timer >= HICCUP_CNT - 1) begin
            seq <= ST_INIT; // R8
            timer <= '0;
          end
        end
        ST_LATCHED: begin
          vref_code <= '0;
          if (!en_ok || !cmp.uvlo_ok || (!soft_en && soft_en_prev)) begin
            seq <= ST_OFF; // R9
          end
        end
        ST_THERMAL: begin
          if (cmp.temp_recovered && !cmp.over_temp) begin
            seq   <= ST_INIT; // R12
            timer <= '0;
          end
        end
        default: seq <= ST_OFF;
      endcase
    end
  end

  // Mode selection: PWM/PFM with hysteresis, buck/boost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfm_mode <= 1'b1;
      boost    <= 1'b0;
    end else begin
      boost <= !cmp.vin_gt_vout; // R21
      if (forced_mode_sel == FM_PWM) begin
        pfm_mode <= 1'b0; // R16
      end else if (pfm_mode && cmp.heavy_load) begin
        pfm_mode <= 1'b0; // R20
      end else if (!pfm_mode && cmp.light_load) begin
        pfm_mode <= 1'b1; // R20
      end
    end
  end

  // Switch phase machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph          <= PH_IDLE;
      dt_cnt      <= '0;
      cycle_boost <= 1'b0;
    end else if (seq != ST_SOFT && seq != ST_RUN) begin
      ph     <= PH_IDLE; // R11
      dt_cnt <= '0;
    end else begin
      case (ph)
        PH_IDLE: begin
          dt_cnt      <= '0;
          cycle_boost <= boost; // R21
          if (!pfm_mode || cmp.vout_lo) begin
            ph <= boost ? PH_AHEAD : PH_ON1; // R18 R25
          end
        end
        PH_AHEAD: begin
          dt_cnt <= dt_cnt + 3'd1;
          if (dt_done) begin
            dt_cnt <= '0;
            ph     <= PH_ON1; // R18 R25
          end
        end
        PH_ON1: begin
          if (cmp.ipk_hi) begin
            ph <= PH_DT1; // R14
          end
        end
        PH_DT1: begin
          dt_cnt <= dt_cnt + 3'd1;
          if (dt_done) begin
            dt_cnt <= '0;
            ph     <= PH_ON2; // R25
          end
        end
        PH_ON2: begin
          if (cmp.ipk_lo) begin
            ph <= PH_DT2; // R14
          end
        end
        PH_DT2: begin
          dt_cnt <= dt_cnt + 3'd1;
          if (dt_done) begin
            dt_cnt <= '0;
            if (pfm_mode && cmp.vout_hi) begin
              ph <= PH_IDLE; // R19
            end else if (pfm_mode) begin
              cycle_boost <= boost;
              ph          <= boost ? PH_AHEAD : PH_ON1; // R19
            end else begin
              cycle_boost <= boost;
              ph          <= (boost && !cycle_boost) ? PH_AHEAD : PH_ON1; // R14 R25
            end
          end
        end
        default: ph <= PH_IDLE;
      endcase
    end
  end

  // Switch decode
  always_comb begin
    next_sw = '0;
    if (bypass) begin
      next_sw.sw_a = 1'b1; // R23
      next_sw.sw_d = 1'b1; // R23
    end else if (seq == ST_SOFT || seq == ST_RUN) begin
      if (!cycle_boost) begin
        next_sw.sw_d = 1'b1; // R13
        next_sw.sw_a = (ph == PH_ON1); // R14
        next_sw.sw_b = (ph == PH_ON2); // R17
      end else begin
        next_sw.sw_a = !pfm_mode || (ph != PH_IDLE); // R15
        next_sw.sw_c = (ph == PH_ON1); // R15
        next_sw.sw_d = (ph == PH_ON2); // R18
      end
    end
  end

  // Registered switch drive, legs never overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw           <= '0;
      discharge_on <= 1'b0;
      bias_on      <= 1'b0;
      regulating   <= 1'b0;
    end else begin
      sw.sw_a      <= next_sw.sw_a && !next_sw.sw_b; // R25
      sw.sw_b      <= next_sw.sw_b && !next_sw.sw_a; // R25
      sw.sw_c      <= next_sw.sw_c && !next_sw.sw_d; // R25
      sw.sw_d      <= next_sw.sw_d && !next_sw.sw_c; // R25
      discharge_on <= en_ok && cmp.uvlo_ok && soft_discharge_en_bit && !soft_en && seq == ST_OFF; // R3 R4
      bias_on      <= en_ok && !bypass; // R23
      regulating   <= (seq == ST_RUN);
    end
  end
endmodule // bbss_top

// ### verification/bbss_checker.sv
`timescale 1ns/10ps
module bbss_checker
  import bbss_pkg::*;
#(
  parameter int unsigned EN_LOW_CNT = EN_LOW_CYCLES
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         en_pin,
  input wire bbss_cmp_type cmp_in,
  input wire logic [7:0]   otp_vset,
  input wire bbss_sw_type  sw,
  input wire logic         discharge_on,
  input wire logic [7:0]   vref_code,
  input wire logic         regulating
);
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin low time, saturating past the filter
  int unsigned low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
    end else if (en_pin) begin
      low_cnt <= 0;
    end else if (low_cnt < EN_LOW_CNT + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_leg; !(sw.sw_a && sw.sw_b) && !(sw.sw_c && sw.sw_d); endproperty
  a_leg: assert property (p_leg) else $error("leg shorted");
  property p_dead_ab; $fell(sw.sw_a) |-> !sw.sw_b [*4]; endproperty
  a_dead_ab: assert property (p_dead_ab) else $error("no dead time A to B");
  property p_dead_cd; $fell(sw.sw_c) |-> !sw.sw_d [*4]; endproperty
  a_dead_cd: assert property (p_dead_cd) else $error("no dead time C to D");
  property p_buck; sw.sw_b |-> sw.sw_d && !sw.sw_c; endproperty
  a_buck: assert property (p_buck) else $error("B on outside buck");
  property p_boost; sw.sw_c |-> sw.sw_a && !sw.sw_b; endproperty
  a_boost: assert property (p_boost) else $error("C on outside boost");
  property p_hot; cmp_in.over_temp [*5] |=> sw == 4'h0; endproperty
  a_hot: assert property (p_hot) else $error("switching while hot");
  property p_ramp;
    $changed(vref_code) && !regulating |->
      vref_code == $past(vref_code) + 8'h01 || vref_code == 8'h00;
  endproperty
  a_ramp: assert property (p_ramp) else $error("reference jumped");
  property p_start; $rose(regulating) |-> vref_code == otp_vset; endproperty
  a_start: assert property (p_start) else $error("target not reached");
  property p_pin_off;
    low_cnt == EN_LOW_CNT + 8 |-> sw == 4'h0 && !discharge_on && !regulating;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin disable ignored");
  property p_soft_discharge_en; discharge_on |-> sw == 4'h0 && !regulating; endproperty
  a_soft_discharge_en: assert property (p_soft_discharge_en) else $error("discharge while running");
endmodule // bbss_checker

bind bbss_top bbss_checker #(.EN_LOW_CNT(EN_LOW_CNT)) u_bbss_checker (
  .pclk(pclk), .presetn(presetn), .en_pin(en_pin), .cmp_in(cmp_in), .otp_vset(otp_vset),
  .sw(sw), .discharge_on(discharge_on), .vref_code(vref_code), .regulating(regulating)
);

// ### verification/bbss_stage_model.sv
`timescale 1ns/10ps
module bbss_stage_model
  import bbss_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire bbss_sw_type sw,
  input  wire logic [6:0]  ctl,
  output bbss_cmp_type     cmp
);
  logic [3:0] cur;
  logic [5:0] vo;
  logic [2:0] tick;
  logic       chg;
  logic       dis;
  // Charging and delivering switch depend on buck or boost
  assign chg = ctl[3] ? sw.sw_a : sw.sw_c;
  assign dis = ctl[3] ? sw.sw_b : sw.sw_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= 4'h0;
      vo <= 6'h1E;
      tick <= 3'h0;
    end else begin
      tick <= tick + 3'h1;
      if (chg && cur != 4'hF) cur <= cur + 4'h1;
      else if (!chg && cur != 4'h0) cur <= cur - 4'h1;
      if (dis && vo != 6'h3F) vo <= vo + 6'h01;
      else if (tick == 3'h0 && vo != 6'h00) vo <= vo - 6'h01;
    end
  end
  assign cmp = {cur >= 4'h6, ctl[6], cur == 4'h0, vo >= 6'h28, vo <= 6'h14, ctl[5:0]};
endmodule // bbss_stage_model

// ### verification/test_buck_boost_switch_sequencer.sv
`timescale 1ns/10ps
module test_buck_boost_switch_sequencer
  import bbss_pkg::*;
;
  localparam logic [7:0]  VS = 8'h10;
  localparam logic [15:0] RP = 16'h0002;
  localparam int          HC = 50;
  localparam int          ST = INIT_CYCLES + VS * RP;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic         en_pin = 1'b0;
  // Stage controls: oc, heavy, light, vin above, hot, cooled, supply ok
  logic [6:0]   ctl = 7'h01;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         discharge_on;
  logic         bias_on;
  logic         regulating;
  logic [7:0]   vref_code;
  logic [31:0]  q;
  logic         e;
  bbss_cmp_type cmp_in;
  bbss_sw_type  sw;
  int           bad_count = 0;
  int           tests_run = 0;
  int           n;
  int           c [6];

  bbss_top #(.EN_LOW_CNT(20), .HICCUP_CNT(HC)) u_bbss_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .en_pin(en_pin), .cmp_in(cmp_in), .otp_vset(VS), .otp_ramp(RP),
    .sw(sw), .discharge_on(discharge_on), .bias_on(bias_on), .vref_code(vref_code),
    .regulating(regulating)
  );
  bbss_stage_model u_bbss_stage_model (
    .pclk(pclk), .presetn(presetn), .sw(sw), .ctl(ctl), .cmp(cmp_in)
  );

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      chk(pready, 1'b1);
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wreg(input logic lvl, input int lim);
    n = 0;
    while (regulating !== lvl) begin
      @(negedge pclk);
      n++;
      if (n > lim) begin
        chk(regulating, lvl);
        tally_and_finish();
      end
    end
    @(posedge pclk);
  endtask

  // Settle 30 cycles, then count switch activity
  task automatic obs(input int w);
    repeat (30) @(posedge pclk);
    c = '{default: 0};
    repeat (w) begin
      @(negedge pclk);
      c[0] += (sw.sw_a === 1'b1);
      c[1] += (sw.sw_b === 1'b1);
      c[2] += (sw.sw_c === 1'b1);
      c[3] += (sw.sw_d === 1'b1);
      c[4] += (sw === 4'h0);
      c[5] += (regulating === 1'b1);
    end
    @(posedge pclk);
  endtask

  task automatic t_regs();
    bus(1'b0, CFG_OFFSET, 32'h0);
    chk(q, CFG_RESET);
    bus(1'b1, CFG_OFFSET, 32'hFFFF_FFC1);
    bus(1'b0, CFG_OFFSET, 32'h0);
    chk(q, 32'h0000_0001);
    bus(1'b1, VSET_OFFSET, 32'h0000_000C);
    bus(1'b0, VSET_OFFSET, 32'h0);
    chk(q, 32'h0000_000C);
    bus(1'b0, 12'h010, 32'h0);
    chk(q, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("regs done");
  endtask

  task automatic t_start();
    ctl <= 7'h11;
    en_pin <= 1'b1;
    wreg(1'b1, 2000);
    chk(n >= ST, 1'b1);
    chk(vref_code, VS);
    $display("start done");
  endtask

  task automatic t_modes();
    ctl[3] <= 1'b1;
    obs(300);
    chk(c[3] == 300 && c[2] == 0 && c[0] > 0 && c[1] > 0, 1'b1);
    chk(c[0] + c[1] < 300, 1'b1);
    ctl[5:3] <= 3'b101;
    obs(300);
    chk(c[3] == 300 && c[2] == 0 && c[0] > 0 && c[1] > 0, 1'b1);
    ctl[5:3] <= 3'b010;
    obs(600);
    chk(c[1] == 0 && c[2] > 0 && c[3] > 0 && c[4] > 0, 1'b1);
    ctl[5:3] <= 3'b100;
    obs(300);
    chk(c[0] == 300 && c[1] == 0 && c[2] > 0 && c[3] > 0, 1'b1);
    ctl[5:3] <= 3'b000;
    obs(300);
    chk(c[0], 300);
    ctl[5:3] <= 3'b010;
    obs(300);
    chk(c[4] > 0, 1'b1);
    bus(1'b1, CFG_OFFSET, 32'h21);
    obs(300);
    chk(c[0], 300);
    bus(1'b1, CFG_OFFSET, 32'h01);
    $display("modes done");
  endtask

  task automatic t_faults();
    ctl[2] <= 1'b1;
    wreg(1'b0, 20);
    obs(100);
    chk(c[4], 100);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    ctl[2:1] <= 2'b01;
    wreg(1'b1, 2000);
    chk(n >= ST, 1'b1);
    chk(vref_code, VS);
    ctl[6:1] <= 6'b100000;
    wreg(1'b0, 20);
    repeat (100) @(posedge pclk);
    ctl[6] <= 1'b0;
    wreg(1'b1, 3000);
    chk(n + 100 >= 2 * HC + INIT_CYCLES + ST, 1'b1);
    bus(1'b1, CFG_OFFSET, 32'h05);
    ctl[6] <= 1'b1;
    wreg(1'b0, 20);
    ctl[6] <= 1'b0;
    obs(200);
    chk(c[5], 0);
    bus(1'b1, CFG_OFFSET, 32'h04);
    bus(1'b1, CFG_OFFSET, 32'h05);
    wreg(1'b1, 2000);
    bus(1'b1, CFG_OFFSET, 32'h09);
    ctl[6] <= 1'b1;
    obs(300);
    chk(c[5] == 300 && c[2] > 0, 1'b1);
    ctl[6] <= 1'b0;
    $display("faults done");
  endtask

  task automatic t_power();
    bus(1'b1, CFG_OFFSET, 32'h02);
    wreg(1'b0, 20);
    obs(10);
    chk({discharge_on, c[4] == 10}, 2'b11);
    en_pin <= 1'b0;
    obs(40);
    chk({discharge_on, bias_on}, 2'b00);
    en_pin <= 1'b1;
    bus(1'b1, CFG_OFFSET, 32'h03);
    wreg(1'b1, 2000);
    en_pin <= 1'b0;
    obs(40);
    chk({discharge_on, regulating, bias_on}, 3'b000);
    en_pin <= 1'b1;
    wreg(1'b1, 2000);
    bus(1'b1, CFG_OFFSET, 32'h11);
    obs(10);
    chk({sw, bias_on}, 5'b10010);
    $display("power done");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_start();
    t_modes();
    t_faults();
    t_power();
    tally_and_finish();
  end
endmodule // test_buck_boost_switch_sequencer
